// ===== design/scp_short_circuit_protect.v
/*
 * Discharge short-circuit protection with load-monitor recovery, plus
 * the cell-balance minimum threshold and balance-undervoltage inhibit.
 * Assumes sense voltage (mV) and highest cell code come from logic on
 * sys_clk_i; the load sense comparator is asynchronous. Registers are
 * reached by a byte-wide port at their documented offsets.
 */
`include "scp_defs.vh"

module scp_short_circuit_protect #(
    parameter LOAD_PULSE_MS = 1 // Test current pulse length, ms
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire [9:0] sense_mv_i,
    input wire discharge_overcurrent_i,
    input wire other_fault_i,
    input wire load_sense_pin_below_i,
    input wire [11:0] cell_max_code_i,
    output reg [7:0] reg_rdata_o,
    output reg charge_switch_on_o,
    output reg discharge_switch_on_o,
    output reg load_monitor_drive_o,
    output reg balance_inhibit_o,
    output reg short_circuit_fault_o
);
    // Recovery states, one-hot
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_WAIT = 4'h2;
    localparam [3:0] ST_MON = 4'h4;
    localparam [3:0] ST_DONE = 4'h8;

    // Configuration registers
    reg [7:0] timer_low_reg; // Delay count low byte
    reg [7:0] thr_unit_reg; // Selector, unit, count high bits
    reg [7:0] bal_min_low_reg; // Balance minimum low byte
    reg [7:0] bal_min_high_reg; // Balance minimum high nibble
    // Control and status bits
    reg sc_fault_reg; // Short-circuit fault flag
    reg load_flag_reg; // Load-present flag
    reg bal_uv_reg; // Balance-undervoltage flag
    reg mon_pulse_reg; // Host load monitor pulse bit
    reg charge_sw_reg; // Charge switch control bit
    reg discharge_sw_reg; // Discharge switch control bit
    reg ownership_reg; // Host owns switch control
    reg override_reg; // Host owns load monitoring
    // Delay and recovery state
    reg [10:0] units_reg; // Units elapsed above threshold
    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg [1:0] wait_s_reg; // Seconds waited before monitoring
    reg [7:0] pulse_ms_reg; // Remaining test pulse length
    reg doc_q_reg; // Last overcurrent level, for edge
    // Load sense pin synchroniser
    reg sync1_reg;
    reg sync2_reg;
    reg sync3_reg;
    reg load_below_reg; // Filtered comparator level

    wire [2:0] thr_sel = thr_unit_reg[6:4];
    wire [1:0] unit_sel = thr_unit_reg[3:2];
    wire [9:0] delay_count = {thr_unit_reg[1:0], timer_low_reg};
    wire [11:0] bal_min = {bal_min_high_reg[3:0], bal_min_low_reg};
    wire wr_timer = reg_wr_i && (reg_addr_i == `SCP_ADDR_TIMER_LOW);
    wire wr_thr = reg_wr_i && (reg_addr_i == `SCP_ADDR_THR_UNIT);
    wire wr_sw = reg_wr_i && (reg_addr_i == `SCP_ADDR_SWITCH_CTRL);
    wire wr_own = reg_wr_i && (reg_addr_i == `SCP_ADDR_OWNER_CTRL);
    wire clr_req = wr_sw && reg_wdata_i[`SCP_BIT_LOAD_ERR_CLR];

    // Time base chain: microsecond up to minute
    wire tick_us;
    wire tick_ms;
    wire tick_s;
    wire tick_min;
    wire tick_mon; // Every 256 ms
    scp_tick_div #(.DIV(`SCP_CYC_PER_US), .W(8)) u_div_us (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .tick_in_i(1'b1), .tick_o(tick_us));
    scp_tick_div #(.DIV(`SCP_US_PER_MS), .W(10)) u_div_ms (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .tick_in_i(tick_us), .tick_o(tick_ms));
    scp_tick_div #(.DIV(`SCP_MS_PER_S), .W(10)) u_div_s (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .tick_in_i(tick_ms), .tick_o(tick_s));
    scp_tick_div #(.DIV(`SCP_S_PER_MIN), .W(6)) u_div_min (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .tick_in_i(tick_s), .tick_o(tick_min));
    scp_tick_div #(.DIV(`SCP_MON_PERIOD_MS), .W(8)) u_div_mon (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .tick_in_i(tick_ms), .tick_o(tick_mon));

    // Threshold lookup in mV
    reg [9:0] thr_mv;
    always @* begin
        case (thr_sel)
            3'h0: thr_mv = 10'h010;
            3'h1: thr_mv = 10'h018;
            3'h2: thr_mv = 10'h020;
            3'h3: thr_mv = 10'h030;
            3'h4: thr_mv = 10'h040;
            3'h5: thr_mv = 10'h060;
            3'h6: thr_mv = 10'h080;
            default: thr_mv = 10'h100;
        endcase
    end

    // Time unit selection for the delay count
    reg unit_tick;
    always @* begin
        case (unit_sel)
            2'h0: unit_tick = tick_us;
            2'h1: unit_tick = tick_ms;
            2'h2: unit_tick = tick_s;
            default: unit_tick = tick_min;
        endcase
    end

    wire over_thr = (sense_mv_i > thr_mv);
    // Delay must be exceeded, not merely reached
    wire sc_declare = over_thr && (units_reg > {1'b0, delay_count}) && !sc_fault_reg;
    wire doc_rise = discharge_overcurrent_i && !doc_q_reg;
    wire start_recovery = sc_declare || doc_rise;
    wire host_mon = override_reg;
    wire sample_now = host_mon ? mon_pulse_reg : load_monitor_drive_o;

    // Count elapsed units while over threshold; saturate at the top
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            units_reg <= 11'h000;
        end else if (!over_thr) begin
            units_reg <= 11'h000;
        end else if (unit_tick && (units_reg != 11'h7FF)) begin
            units_reg <= units_reg + 11'h001;
        end
    end

    // Three-stage synchroniser; level moves when stages two and three agree
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            load_below_reg <= 1'b0;
        end else begin
            sync1_reg <= load_sense_pin_below_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            if (sync2_reg == sync3_reg) begin
                load_below_reg <= sync3_reg;
            end
        end
    end

    // Recovery sequencer next state
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: if (start_recovery) state_next = ST_WAIT;
            ST_WAIT: if (tick_s && (wait_s_reg == `SCP_RECOVERY_WAIT_S - 1)) state_next = ST_MON;
            ST_MON: if (!sc_fault_reg && !discharge_overcurrent_i && !load_flag_reg)
                state_next = ST_DONE;
            ST_DONE: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // Sequencer state, wait counter and monitor pulse timing
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            wait_s_reg <= 2'h0;
            pulse_ms_reg <= 8'h00;
            load_monitor_drive_o <= 1'b0;
            doc_q_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            doc_q_reg <= discharge_overcurrent_i;
            if (state_reg != ST_WAIT) begin
                wait_s_reg <= 2'h0;
            end else if (tick_s) begin
                wait_s_reg <= wait_s_reg + 2'h1;
            end
            // Own pulses only while monitoring and not overridden
            if ((state_reg == ST_MON) && !host_mon) begin
                if (tick_mon && !load_monitor_drive_o) begin
                    load_monitor_drive_o <= 1'b1;
                    pulse_ms_reg <= LOAD_PULSE_MS[7:0];
                end else if (load_monitor_drive_o && tick_ms) begin
                    if (pulse_ms_reg <= 8'h01) begin
                        load_monitor_drive_o <= 1'b0;
                    end
                    pulse_ms_reg <= pulse_ms_reg - 8'h01;
                end
            end else begin
                load_monitor_drive_o <= host_mon && mon_pulse_reg;
                pulse_ms_reg <= 8'h00;
            end
        end
    end

    // Fault and load flags; a new fault wins over a clear in the same cycle
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            sc_fault_reg <= 1'b0;
            load_flag_reg <= 1'b0;
        end else begin
            if (sc_declare) begin
                sc_fault_reg <= 1'b1;
            end else if (host_mon && clr_req) begin
                sc_fault_reg <= 1'b0;
            end else if (!host_mon && !ownership_reg && (state_reg == ST_MON) &&
                         !load_flag_reg) begin
                sc_fault_reg <= 1'b0;
            end else if (ownership_reg && !host_mon && (state_reg == ST_MON) &&
                         !load_flag_reg) begin
                sc_fault_reg <= 1'b0;
            end
            if (start_recovery) begin
                load_flag_reg <= 1'b1;
            end else if (((state_reg == ST_MON) || host_mon) && sample_now) begin
                load_flag_reg <= load_below_reg;
            end
        end
    end

    // Configuration registers with reserved bits held at zero
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            timer_low_reg <= `SCP_RST_TIMER_LOW;
            thr_unit_reg <= `SCP_RST_THR_UNIT;
            bal_min_low_reg <= `SCP_RST_BAL_MIN_LOW;
            bal_min_high_reg <= `SCP_RST_BAL_MIN_HIGH;
        end else if (reg_wr_i) begin
            if (wr_timer) timer_low_reg <= reg_wdata_i;
            // Top bit dropped even if host writes it
            if (wr_thr) thr_unit_reg <= reg_wdata_i & `SCP_THR_UNIT_MASK;
            if (reg_addr_i == `SCP_ADDR_BAL_MIN_LOW) bal_min_low_reg <= reg_wdata_i;
            if (reg_addr_i == `SCP_ADDR_BAL_MIN_HIGH)
                bal_min_high_reg <= reg_wdata_i & `SCP_BAL_HIGH_MASK;
        end
    end

    // Switch control and ownership bits
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            charge_sw_reg <= 1'b1;
            discharge_sw_reg <= 1'b1;
            mon_pulse_reg <= 1'b0;
            ownership_reg <= 1'b0;
            override_reg <= 1'b0;
        end else begin
            if (wr_own) begin
                ownership_reg <= reg_wdata_i[`SCP_BIT_OWNERSHIP];
                override_reg <= reg_wdata_i[`SCP_BIT_MON_OVERRIDE];
            end
            if (wr_sw) begin
                mon_pulse_reg <= reg_wdata_i[`SCP_BIT_MON_PULSE];
            end
            if (start_recovery) begin
                // Fault drop beats a host write landing in the same cycle
                charge_sw_reg <= 1'b0;
                discharge_sw_reg <= 1'b0;
            end else if ((state_reg == ST_DONE) && !ownership_reg && !other_fault_i) begin
                charge_sw_reg <= 1'b1;
                discharge_sw_reg <= 1'b1;
            end else if (wr_sw) begin
                charge_sw_reg <= reg_wdata_i[`SCP_BIT_CHARGE_SW];
                discharge_sw_reg <= reg_wdata_i[`SCP_BIT_DISCHARGE_SW];
            end
        end
    end

    // Balance undervoltage: highest cell below minimum means all are
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            bal_uv_reg <= 1'b0;
            balance_inhibit_o <= 1'b0;
        end else begin
            // Same code scale on both sides, so raw codes compare directly
            bal_uv_reg <= (cell_max_code_i < bal_min);
            balance_inhibit_o <= (cell_max_code_i < bal_min);
        end
    end

    // Switch outputs gated by the short-circuit fault regardless of ownership
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            charge_switch_on_o <= 1'b0;
            discharge_switch_on_o <= 1'b0;
            short_circuit_fault_o <= 1'b0;
        end else begin
            charge_switch_on_o <= charge_sw_reg && !sc_fault_reg && !sc_declare;
            discharge_switch_on_o <= discharge_sw_reg && !sc_fault_reg && !sc_declare;
            short_circuit_fault_o <= sc_fault_reg;
        end
    end

    // Registered read mux; unmapped offsets read zero
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            case (reg_addr_i)
                `SCP_ADDR_TIMER_LOW: reg_rdata_o <= timer_low_reg;
                `SCP_ADDR_THR_UNIT: reg_rdata_o <= thr_unit_reg;
                `SCP_ADDR_BAL_MIN_LOW: reg_rdata_o <= bal_min_low_reg;
                `SCP_ADDR_BAL_MIN_HIGH: reg_rdata_o <= bal_min_high_reg;
                `SCP_ADDR_FAULT_STATUS: reg_rdata_o <= {4'h0, sc_fault_reg, 3'h0};
                `SCP_ADDR_LOAD_STATUS: reg_rdata_o <= {7'h00, load_flag_reg};
                `SCP_ADDR_BAL_STATUS: reg_rdata_o <= {4'h0, bal_uv_reg, 3'h0};
                `SCP_ADDR_SWITCH_CTRL:
                    reg_rdata_o <= {1'b0, mon_pulse_reg, 4'h0, charge_sw_reg, discharge_sw_reg};
                `SCP_ADDR_OWNER_CTRL:
                    reg_rdata_o <= {1'b0, ownership_reg, 1'b0, override_reg, 4'h0};
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end
endmodule

// ===== design/scp_defs.vh
/*
 * Constants for the short-circuit protection and balance-minimum block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 20 MHz system clock and byte-wide register access.
 */
`ifndef SCP_DEFS_VH
`define SCP_DEFS_VH

// Register offsets
`define SCP_ADDR_TIMER_LOW 8'h1A
`define SCP_ADDR_THR_UNIT 8'h1B
`define SCP_ADDR_BAL_MIN_LOW 8'h1C
`define SCP_ADDR_BAL_MIN_HIGH 8'h1D
`define SCP_ADDR_FAULT_STATUS 8'h81
`define SCP_ADDR_LOAD_STATUS 8'h82
`define SCP_ADDR_BAL_STATUS 8'h83
`define SCP_ADDR_SWITCH_CTRL 8'h86
`define SCP_ADDR_OWNER_CTRL 8'h87

// Reset values
`define SCP_RST_TIMER_LOW 8'hC8
`define SCP_RST_THR_UNIT 8'h60
`define SCP_RST_BAL_MIN_LOW 8'h55
`define SCP_RST_BAL_MIN_HIGH 8'h0A

// Field positions and write masks
`define SCP_THR_UNIT_MASK 8'h7F
`define SCP_BAL_HIGH_MASK 8'h0F
`define SCP_BIT_SC_FAULT 3
`define SCP_BIT_LOAD_PRESENT 0
`define SCP_BIT_BAL_UV 3
`define SCP_BIT_LOAD_ERR_CLR 7
`define SCP_BIT_MON_PULSE 6
`define SCP_BIT_CHARGE_SW 1
`define SCP_BIT_DISCHARGE_SW 0
`define SCP_BIT_OWNERSHIP 6
`define SCP_BIT_MON_OVERRIDE 4

// Timing: clock rate and derived cycle counts
`define SCP_CLK_HZ 20000000
`define SCP_CYC_PER_US (`SCP_CLK_HZ / 1000000)
`define SCP_US_PER_MS 1000
`define SCP_MS_PER_S 1000
`define SCP_S_PER_MIN 60
`define SCP_MON_PERIOD_MS 256
`define SCP_RECOVERY_WAIT_S 3

`endif

// ===== design/scp_tick_div.v
/*
 * Tick divider: emits one pulse per DIV input ticks.
 * Assumes tick_in_i is a one-cycle pulse on sys_clk_i.
 */
module scp_tick_div #(
    parameter DIV = 20, // Input ticks per output tick
    parameter W = 16 // Counter width
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire tick_in_i,
    output reg tick_o
);
    localparam [W-1:0] LAST = DIV[W-1:0] - 1'b1; // Terminal count
    reg [W-1:0] cnt_reg; // Input ticks seen

    // Count input ticks, wrap and pulse at the terminal count
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            cnt_reg <= {W{1'b0}};
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (tick_in_i) begin
                if (cnt_reg == LAST) begin
                    cnt_reg <= {W{1'b0}};
                    tick_o <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// ===== test/scp_short_circuit_protect_sva.sv
/*
 * Port-level checker for the short-circuit protection block, bound in.
 * Assumes byte writes on reg_wr_i and one clock domain, sys_clk_i.
 */
module scp_short_circuit_protect_sva #(
    parameter LOAD_PULSE_MS = 1
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire [9:0] sense_mv_i,
    input wire discharge_overcurrent_i,
    input wire other_fault_i,
    input wire load_sense_pin_below_i,
    input wire [11:0] cell_max_code_i,
    input wire [7:0] reg_rdata_o,
    input wire charge_switch_on_o,
    input wire discharge_switch_on_o,
    input wire load_monitor_drive_o,
    input wire balance_inhibit_o,
    input wire short_circuit_fault_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [9:0] THR [8] = '{10'h010, 10'h018, 10'h020, 10'h030, 10'h040,
        10'h060, 10'h080, 10'h100};
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    logic [7:0] sh_1a, sh_1b, sh_1c, sh_1d; // Shadow of the config bytes
    logic ovr_q; // Shadow of host override
    logic [15:0] run; // Consecutive cycles above threshold
    logic [7:0] exp_rd;
    wire [9:0] thr = THR[sh_1b[6:4]];
    wire [15:0] dly_cyc = {6'h00, sh_1b[1:0], sh_1a} * 16'h0014;
    wire [11:0] bal_min = {sh_1d[3:0], sh_1c};
    // Shadow writes, reserved bits dropped as the block does
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            sh_1a <= 8'hC8;
            sh_1b <= 8'h60;
            sh_1c <= 8'h55;
            sh_1d <= 8'h0A;
            ovr_q <= 1'b0;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                8'h1A: sh_1a <= reg_wdata_i;
                8'h1B: sh_1b <= reg_wdata_i & 8'h7F;
                8'h1C: sh_1c <= reg_wdata_i;
                8'h1D: sh_1d <= reg_wdata_i & 8'h0F;
                8'h87: ovr_q <= reg_wdata_i[4];
                default: ;
            endcase
        end
    end
    // Run length restarts on any dip, so spikes never add up
    always @(posedge sys_clk_i) begin
        if (rst_i || sense_mv_i <= thr) begin
            run <= 16'h0000;
        end else if (run != 16'hFFFF) begin
            run <= run + 16'h0001;
        end
    end
    // Expected read data; holes below the block read zero
    always @* begin
        case (reg_addr_i)
            8'h1A: exp_rd = sh_1a;
            8'h1B: exp_rd = sh_1b;
            8'h1C: exp_rd = sh_1c;
            8'h1D: exp_rd = sh_1d;
            default: exp_rd = 8'h00;
        endcase
    end
    sequence low_rd_s;
        !$past(rst_i) && $past(reg_addr_i) < 8'h1C;
    endsequence
    sequence bal_rd_s;
        !$past(rst_i) && ($past(reg_addr_i) == 8'h1C || $past(reg_addr_i) == 8'h1D);
    endsequence
    sequence cell_low_s;
        (cell_max_code_i < bal_min) [*4];
    endsequence
    sequence cell_ok_s;
        (cell_max_code_i >= bal_min) [*4];
    endsequence
    sequence clr_wr_s;
        reg_wr_i && reg_addr_i == 8'h86 && reg_wdata_i[7] && ovr_q && sense_mv_i <= 10'h010;
    endsequence
    sequence on_wr_s;
        reg_wr_i && reg_addr_i == 8'h86 && reg_wdata_i[1:0] == 2'b11 && !short_circuit_fault_o
            && !other_fault_i && !discharge_overcurrent_i;
    endsequence
    cfg_read_a: assert property (low_rd_s |-> reg_rdata_o == $past(exp_rd))
        else $error("config read data wrong");
    bal_read_a: assert property (bal_rd_s |-> reg_rdata_o == $past(exp_rd))
        else $error("balance read data wrong");
    flag_mirror_a: assert property (!$past(rst_i) && $past(reg_addr_i) == 8'h81
        |-> reg_rdata_o[3] == short_circuit_fault_o) else $error("fault flag read wrong");
    fault_off_a: assert property ($rose(short_circuit_fault_o)
        |-> (!charge_switch_on_o && !discharge_switch_on_o) [*3]) else $error("switch on in fault");
    thr_cross_a: assert property ($rose(short_circuit_fault_o)
        |-> $past(sense_mv_i, 2) > thr || $past(sense_mv_i, 3) > thr) else $error("fault below thr");
    delay_min_a: assert property ($rose(short_circuit_fault_o) |-> run >= dly_cyc)
        else $error("fault before delay");
    bal_low_a: assert property (cell_low_s |-> balance_inhibit_o)
        else $error("balance not inhibited");
    bal_ok_a: assert property (cell_ok_s |-> !balance_inhibit_o)
        else $error("balance wrongly inhibited");
    host_clear_a: assert property (clr_wr_s |-> ##[2:4] !short_circuit_fault_o)
        else $error("clear write ignored");
    host_on_a: assert property (on_wr_s |-> ##[1:3] charge_switch_on_o && discharge_switch_on_o)
        else $error("switches not re-enabled");
endmodule

bind scp_short_circuit_protect scp_short_circuit_protect_sva #(
    .LOAD_PULSE_MS(LOAD_PULSE_MS)
) i_scp_short_circuit_protect_sva (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .sense_mv_i(sense_mv_i), .discharge_overcurrent_i(discharge_overcurrent_i),
    .other_fault_i(other_fault_i), .load_sense_pin_below_i(load_sense_pin_below_i),
    .cell_max_code_i(cell_max_code_i), .reg_rdata_o(reg_rdata_o),
    .charge_switch_on_o(charge_switch_on_o), .discharge_switch_on_o(discharge_switch_on_o),
    .load_monitor_drive_o(load_monitor_drive_o), .balance_inhibit_o(balance_inhibit_o),
    .short_circuit_fault_o(short_circuit_fault_o)
);

// ===== test/scp_host_model.sv
/*
 * Host model on the byte register port: writes and reads.
 * Assumes read data follows the address one edge later.
 */
module scp_host_model (
    input wire logic sys_clk_i,
    input wire logic [7:0] reg_rdata_i,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle port at time zero
    initial begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o = 1'b0;
    end
    // Callers pass zero in reserved bits except in refusal tests
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_o <= 1'b0;
        reg_wdata_o <= ~d; // Stale data must not look valid
    endtask
    // Answer taken one edge after it lands
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_o <= a;
        @(posedge sys_clk_i);
        @(posedge sys_clk_i);
        d = reg_rdata_i;
    endtask
endmodule

// ===== test/scp_short_circuit_protect_tb.sv
/*
 * Self-checking bench for the short-circuit protection block.
 * Assumes the host model and the bound checker are compiled alongside.
 */
module scp_short_circuit_protect_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i;
    logic rst_i;
    logic [9:0] sense_mv_i;
    logic [11:0] cell_max_code_i;
    logic ld_pin, discharge_overcurrent;
    wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    wire reg_wr_i, charge_switch_on_o, discharge_switch_on_o, load_monitor_drive_o;
    wire balance_inhibit_o, short_circuit_fault_o;
    int fail_count;
    int num_checks;
    int c, i;
    logic [31:0] lfsr; // Random source, fixed start
    logic [9:0] n;
    logic [11:0] t;
    scp_short_circuit_protect i_scp_short_circuit_protect (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .sense_mv_i(sense_mv_i),
        .discharge_overcurrent_i(discharge_overcurrent), .other_fault_i(1'b0), .load_sense_pin_below_i(ld_pin),
        .cell_max_code_i(cell_max_code_i), .reg_rdata_o(reg_rdata_o),
        .charge_switch_on_o(charge_switch_on_o), .discharge_switch_on_o(discharge_switch_on_o),
        .load_monitor_drive_o(load_monitor_drive_o), .balance_inhibit_o(balance_inhibit_o),
        .short_circuit_fault_o(short_circuit_fault_o)
    );
    scp_host_model i_scp_host_model (
        .sys_clk_i(sys_clk_i), .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
        .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i)
    );
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Threshold in mV for each selector code
    function automatic logic [9:0] thr_mv(input logic [2:0] k);
        case (k)
            3'h0: return 10'h010;
            3'h1: return 10'h018;
            3'h2: return 10'h020;
            3'h3: return 10'h030;
            3'h4: return 10'h040;
            3'h5: return 10'h060;
            3'h6: return 10'h080;
            default: return 10'h100;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        logic [7:0] d;
        i_scp_host_model.rd_reg(a, d);
        chk($sformatf("reg %h", a), {4'h0, e & m}, {4'h0, d & m});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_scp_host_model.wr_reg(a, d);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk_i);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // 20 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    // Watchdog well past the longest expected run
    initial begin
        repeat (100000) @(posedge sys_clk_i);
        fail_count++;
        report_and_stop();
    end
    initial begin
        rst_i = 1'b1;
        sense_mv_i = 10'h000;
        cell_max_code_i = 12'h000;
        {ld_pin, discharge_overcurrent} = 2'b00;
        lfsr = 32'h1cf4_7709;
        fail_count = 0;
        num_checks = 0;
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rdc(8'h1A, 8'hC8, 8'hFF);
        rdc(8'h1B, 8'h60, 8'h7F);
        rdc(8'h1C, 8'h55, 8'hFF);
        rdc(8'h1D, 8'h0A, 8'h0F);
        rdc(8'h05, 8'h00, 8'hFF);
        chk("discharge switch", 1'b1, discharge_switch_on_o);
        wr(8'h1B, 8'hFF);
        rdc(8'h1B, 8'h7F, 8'hFF);
        wr(8'h1D, 8'hFF);
        rdc(8'h1D, 8'h0F, 8'hFF);
        $display("test reset and layout done");
        // Every code: at threshold, spike, early look, then trip
        for (c = 0; c < 8; c++) begin
            lfsr = lfsr_step(lfsr);
            n = {8'h00, lfsr[1:0]} + 10'h001;
            wr(8'h87, {1'b0, c[0], 6'h10}); // Override on, ownership alternates
            wr(8'h1A, n[7:0]);
            wr(8'h1B, {1'b0, c[2:0], 4'h0});
            sense_mv_i <= thr_mv(c[2:0]);
            cyc(300);
            chk("fault at threshold", 1'b0, short_circuit_fault_o);
            sense_mv_i <= thr_mv(c[2:0]) + {7'h00, lfsr[4:2]} + 10'h001;
            cyc(n * 20 - 5);
            sense_mv_i <= 10'h000;
            cyc(5);
            chk("fault after spike", 1'b0, short_circuit_fault_o);
            sense_mv_i <= thr_mv(c[2:0]) + 10'h001;
            cyc(n * 20);
            chk("fault early", 1'b0, short_circuit_fault_o);
            for (i = 0; i < 60 && short_circuit_fault_o !== 1'b1; i++)
                @(posedge sys_clk_i);
            chk("fault", 1'b1, short_circuit_fault_o);
            chk("switches", 2'h0, {charge_switch_on_o, discharge_switch_on_o});
            rdc(8'h81, 8'h08, 8'h08);
            rdc(8'h82, 8'h01, 8'h01);
            sense_mv_i <= 10'h000;
            wr(8'h86, 8'h80);
            rdc(8'h81, 8'h00, 8'h08);
            $display("test threshold %0d done", c);
        end
        // Slower units must not trip inside a 50 microsecond window
        for (c = 1; c < 4; c++) begin
            wr(8'h1A, 8'h01);
            wr(8'h1B, {4'h6, c[1:0], 2'h0});
            sense_mv_i <= 10'h0C8;
            cyc(1000);
            chk("unit", 1'b0, short_circuit_fault_o);
            sense_mv_i <= 10'h000;
        end
        $display("test units done");
        // Random balance minimum, one code below it and at it
        for (c = 0; c < 3; c++) begin
            lfsr = lfsr_step(lfsr);
            t = lfsr[11:0] | 12'h001;
            wr(8'h1C, t[7:0]);
            wr(8'h1D, {4'h0, t[11:8]});
            cell_max_code_i <= t - 12'h001;
            cyc(5);
            chk("inhibit low", 1'b1, balance_inhibit_o);
            rdc(8'h83, 8'h08, 8'h08);
            cell_max_code_i <= t;
            cyc(5);
            chk("inhibit at min", 1'b0, balance_inhibit_o);
        end
        $display("test balance done");
        // Host-paced load check, then host turns switches on
        ld_pin <= 1'b1;
        wr(8'h86, 8'h40);
        cyc(4);
        chk("monitor drive", 1'b1, load_monitor_drive_o);
        rdc(8'h82, 8'h01, 8'h01);
        ld_pin <= 1'b0;
        cyc(6);
        rdc(8'h82, 8'h00, 8'h01);
        wr(8'h86, 8'h00);
        wr(8'h86, 8'h03);
        cyc(3);
        chk("switches on", 2'h3, {charge_switch_on_o, discharge_switch_on_o});
        discharge_overcurrent <= 1'b1;
        cyc(3);
        chk("overcurrent", 2'h0, {charge_switch_on_o, discharge_switch_on_o});
        $display("test host recovery done");
        report_and_stop();
    end
endmodule
